// ### rtl/sdfl_top.sv
// Purpose: Three-wire serial frame loader of a 16-bit string converter.
// Assumes: sclk stands still outside frames; clk runs free at 100 MHz.
//          rst is applied while the link is idle.
// Notes:   Frames are captured on sclk, cross by toggle, pass a FIFO.
//          A frame that meets a full FIFO is dropped; frame_ready warns.
//          tap_switch is 2**SW_W wide; keep SW_W small in simulation.
//          Every output is a flop of the clk domain.
`include "sdfl_consts.svh"

module sdfl_top #(
   parameter int SW_W = `SDFL_CODE_W
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      sclk,
   input  wire logic                      sync_n,
   input  wire logic                      din,
   input  wire logic                      update_hold,
   output logic                           frame_ready,
   output logic [`SDFL_CODE_W-1:0]        dac_code,
   output sdfl_pkg::sdfl_pmode_t          power_mode,
   output logic                           amp_enable,
   output logic                           pulldown_1k,
   output logic                           pulldown_100k,
   output logic                           out_hiz,
   output logic [(1<<SW_W)-1:0]           tap_switch
);
   timeunit 1ns;
   timeprecision 1ps;
   import sdfl_pkg::*;

   // ==================================================================
   // Elaboration check: the tap vector is 2**SW_W wide, so a large SW_W
   // costs many flops; more than the code width has no meaning
   if (SW_W < 1 || SW_W > `SDFL_CODE_W) begin : g_bad_sw_w
      $error("sdfl_top: SW_W must be 1..16");
   end

   // ==================================================================
   // Link domain, clocked by falling sclk
   // bit_cnt_ff counts the falling edges of a frame, 0 to 24
   logic [`SDFL_CNT_W-1:0]     bit_cnt_ff;
   logic [`SDFL_FRAME_BITS-2:0] shift_ff;
   sdfl_word_t                 hold_ff;
   logic                       frame_tog_ff;

   // Select high holds the shifter cleared; an early rise discards the frame.
   // The clear is asynchronous, so a rise between sclk edges takes effect at
   // once and needs no further sclk edge, which the host cannot promise.
   wire link_clr   = rst | sync_n;
   wire last_edge  = (bit_cnt_ff == `SDFL_LAST_EDGE);
   // Edges after the 24th are ignored until select goes high again
   wire frame_done = (bit_cnt_ff == `SDFL_DONE_CNT);
   wire hold_load  = ~sync_n & last_edge;
   wire [`SDFL_FRAME_BITS-1:0] full_frame = {shift_ff, din};
   wire [`SDFL_CNT_W-1:0]      nxt_bit_cnt = bit_cnt_ff + `SDFL_CNT_W'(1);
   wire [`SDFL_FRAME_BITS-2:0] nxt_shift   = full_frame[`SDFL_FRAME_BITS-2:0];

   always_ff @(negedge sclk or posedge link_clr) begin
      if (link_clr) begin
         bit_cnt_ff <= `SDFL_CNT_RST;
         shift_ff   <= '0;
      end else if (!frame_done) begin
         bit_cnt_ff <= nxt_bit_cnt;
         shift_ff   <= nxt_shift;
      end
   end

   // Held word only changes on a completed frame, so it is stable
   // for many clk cycles around the toggle it travels with
   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         hold_ff      <= `SDFL_WORD_RST;
         frame_tog_ff <= 1'b0;
      end else if (hold_load) begin
         hold_ff      <= full_frame[`SDFL_WORD_W-1:0];
         frame_tog_ff <= ~frame_tog_ff;
      end
   end

   // ==================================================================
   // Crossing into clk
   // tog_s1_ff may go metastable; only tog_s2_ff reads it
   logic tog_s1_ff;
   logic tog_s2_ff;
   logic tog_s3_ff;
   sdfl_word_t word_ff;
   logic       word_vld_ff;

   // Only the toggle is synchronised. The word is sampled once the second
   // stage has settled, two to three clk cycles after its last change, and
   // the next frame cannot change it for at least 23 sclk periods.
   wire frame_evt = tog_s2_ff ^ tog_s3_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tog_s1_ff   <= 1'b0;
         tog_s2_ff   <= 1'b0;
         tog_s3_ff   <= 1'b0;
         word_ff     <= `SDFL_WORD_RST;
         word_vld_ff <= 1'b0;
      end else begin
         tog_s1_ff   <= frame_tog_ff;
         tog_s2_ff   <= tog_s1_ff;
         tog_s3_ff   <= tog_s2_ff;
         word_vld_ff <= frame_evt;
         if (frame_evt) begin
            word_ff <= hold_ff;
         end
      end
   end

   // ==================================================================
   // Buffer: a word offered while full is lost, which frame_ready shows.
   // update_hold stalls the drain; four frames wait, the fifth is dropped.
   // Dropping the newest keeps any back-pressure path out of the link,
   // which has no way to stall a host anyway.
   wire        fifo_in_ready;
   wire        fifo_out_valid;
   sdfl_word_t fifo_out_data;
   wire        do_update = fifo_out_valid & ~update_hold;

   sdfl_fifo #(
      .WIDTH(`SDFL_WORD_W),
      .DEPTH(`SDFL_FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .in_valid (word_vld_ff),
      .in_ready (fifo_in_ready),
      .in_data  (word_ff),
      .out_valid(fifo_out_valid),
      .out_ready(~update_hold),
      .out_data (fifo_out_data)
   );

   assign frame_ready = fifo_in_ready;

   // ==================================================================
   // Converter register, mode and output stage. Code and mode load together
   // five or six clk edges after the 24th falling sclk edge when the FIFO
   // is empty and update_hold is low; the decoded controls follow one later.
   logic [`SDFL_CODE_W-1:0] code_ff;
   sdfl_pmode_t             mode_ff;
   logic                    amp_en_ff;
   logic                    pd1k_ff;
   logic                    pd100k_ff;
   logic                    hiz_ff;
   logic [(1<<SW_W)-1:0]    tap_ff;

   wire [`SDFL_CODE_W-1:0] nxt_code = fifo_out_data[`SDFL_CODE_HI:0];
   wire sdfl_pmode_t nxt_mode =
      sdfl_pmode_t'(fifo_out_data[`SDFL_MODE_HI:`SDFL_MODE_LO]);
   // Top SW_W bits pick the tap; lower bits stay in the converter register
   wire [SW_W-1:0] tap_idx = code_ff[`SDFL_CODE_W-1 -: SW_W];

   // One-hot tap select: only one switch of the string ever closes.
   // A wide SW_W makes this a large decoder; it is the price of a flat vector.
   function automatic logic [(1<<SW_W)-1:0] onehot(input logic [SW_W-1:0] idx);
      logic [(1<<SW_W)-1:0] v;
      v      = '0;
      v[idx] = 1'b1;
      return v;
   endfunction : onehot

   // Output stage decode, registered one clk behind the held mode and code
   wire                  nxt_amp_en = (mode_ff == SDFL_PM_NORMAL_E);
   wire                  nxt_pd1k   = (mode_ff == SDFL_PM_1K_E);
   wire                  nxt_pd100k = (mode_ff == SDFL_PM_100K_E);
   wire                  nxt_hiz    = (mode_ff == SDFL_PM_HIZ_E);
   wire [(1<<SW_W)-1:0]  nxt_tap    = onehot(tap_idx);

   // Reset leaves zero code in normal mode: the output stays at ground
   // until the first complete frame
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         code_ff <= `SDFL_CODE_RST;
         mode_ff <= SDFL_PM_NORMAL_E;
      end else if (do_update) begin
         code_ff <= nxt_code;
         mode_ff <= nxt_mode;
      end
   end

   // Power-down only switches the output stage; code_ff still loads the frame's code
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         amp_en_ff <= 1'b1;
         pd1k_ff   <= 1'b0;
         pd100k_ff <= 1'b0;
         hiz_ff    <= 1'b0;
         tap_ff    <= '0;
      end else begin
         amp_en_ff <= nxt_amp_en;
         pd1k_ff   <= nxt_pd1k;
         pd100k_ff <= nxt_pd100k;
         hiz_ff    <= nxt_hiz;
         tap_ff    <= nxt_tap;
      end
   end

   // ==================================================================
   // Outputs: every pin is a flop, so no decode glitch reaches a switch
   assign dac_code      = code_ff;
   assign power_mode    = mode_ff;
   assign amp_enable    = amp_en_ff;
   assign pulldown_1k   = pd1k_ff;
   assign pulldown_100k = pd100k_ff;
   assign out_hiz       = hiz_ff;
   assign tap_switch    = tap_ff;

endmodule : sdfl_top

// ### rtl/sdfl_consts.svh
// Purpose: Shared constants of the serial converter frame loader.
// Assumes: Included by its bare name from package and modules.
// Notes:   Definitions only.
`ifndef SDFL_CONSTS_SVH
`define SDFL_CONSTS_SVH

// =====================================================================
// Frame layout
`define SDFL_FRAME_BITS   24
`define SDFL_CNT_W        5
`define SDFL_LAST_EDGE    5'h17
`define SDFL_DONE_CNT     5'h18
`define SDFL_CNT_RST      5'h00
`define SDFL_CODE_W       16
`define SDFL_WORD_W       18
`define SDFL_MODE_HI      17
`define SDFL_MODE_LO      16
`define SDFL_CODE_HI      15

// =====================================================================
// Power mode encodings and reset values
`define SDFL_PM_NORMAL    2'h0
`define SDFL_PM_1K        2'h1
`define SDFL_PM_100K      2'h2
`define SDFL_PM_HIZ       2'h3
`define SDFL_CODE_RST     16'h0000
`define SDFL_WORD_RST     18'h00000

// =====================================================================
// Buffering
`define SDFL_FIFO_DEPTH   4

`endif

// ### rtl/sdfl_pkg.sv
// Purpose: Types of the serial converter frame loader.
// Assumes: sdfl_consts.svh provides the numeric constants.
// Notes:   Power mode encoding follows the two mode bits of the frame.
`include "sdfl_consts.svh"

package sdfl_pkg;
   timeunit 1ns;
   timeprecision 1ps;

   // ==================================================================
   // Types
   typedef enum logic [1:0] {
      SDFL_PM_NORMAL_E = `SDFL_PM_NORMAL,
      SDFL_PM_1K_E     = `SDFL_PM_1K,
      SDFL_PM_100K_E   = `SDFL_PM_100K,
      SDFL_PM_HIZ_E    = `SDFL_PM_HIZ
   } sdfl_pmode_t;

   typedef logic [`SDFL_WORD_W-1:0] sdfl_word_t;

endpackage : sdfl_pkg

// ### rtl/sdfl_fifo.sv
// Purpose: Small synchronous FIFO between frame capture and update.
// Assumes: One clock; asynchronous active-high reset.
// Notes:   Full and empty are registered; in_ready comes from a flop.
`include "sdfl_consts.svh"

module sdfl_fifo #(
   parameter int WIDTH = `SDFL_WORD_W,
   parameter int DEPTH = `SDFL_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   timeunit 1ns;
   timeprecision 1ps;
   import sdfl_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
      $error("sdfl_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic             room_ff;
   logic             empty_ff;

   wire              do_push = in_valid & room_ff;
   wire              do_pop  = ~empty_ff & out_ready;
   wire [AW:0]       nxt_count = count_ff + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};

   assign in_ready  = room_ff;
   assign out_valid = ~empty_ff;
   assign out_data  = mem_ff[rd_ptr_ff];

   // ==================================================================
   // Storage is not reset; only pointers and flags need a defined value
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
         room_ff   <= 1'b1;
         empty_ff  <= 1'b1;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + AW'(do_push);
         rd_ptr_ff <= rd_ptr_ff + AW'(do_pop);
         count_ff  <= nxt_count;
         room_ff   <= (nxt_count != (AW+1)'(DEPTH));
         empty_ff  <= (nxt_count == '0);
      end
   end

endmodule : sdfl_fifo

// ### test/sdfl_asserts.sv
// Purpose: Port checks of the frame loader.
// Assumes: Outputs live in the clk domain; sclk is watched as data.
// Notes:   Bound to sdfl_top after the module.
`include "sdfl_consts.svh"

module sdfl_asserts #(
   parameter int SW_W = 16
) (
   input wire logic                    clk,
   input wire logic                    rst,
   input wire logic                    sclk,
   input wire logic                    update_hold,
   input wire logic                    frame_ready,
   input wire logic [`SDFL_CODE_W-1:0] dac_code,
   input wire sdfl_pkg::sdfl_pmode_t   power_mode,
   input wire logic                    amp_enable,
   input wire logic                    pulldown_1k,
   input wire logic                    pulldown_100k,
   input wire logic                    out_hiz,
   input wire logic [(1<<SW_W)-1:0]    tap_switch
);
   timeunit 1ns;
   timeprecision 1ps;
   import sdfl_pkg::*;
   // ==========
   // Link quiet counter; 20 cycles covers latency plus a drained backlog
   logic [4:0] quiet_ff;
   logic [4:0] nxt_quiet;
   assign nxt_quiet = (quiet_ff == 5'h1F) ? quiet_ff : quiet_ff + 5'h01;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) quiet_ff <= 5'h00;
      else if ($changed(sclk) || update_hold) quiet_ff <= 5'h00;
      else quiet_ff <= nxt_quiet;
   end
   // ==========
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   amp_decode_a: assert property ($stable(power_mode) |->
      amp_enable == (power_mode == SDFL_PM_NORMAL_E)) else $error("amp decode");
   low_ohm_a: assert property ($stable(power_mode) |->
      pulldown_1k == (power_mode == SDFL_PM_1K_E)) else $error("1k decode");
   high_ohm_a: assert property ($stable(power_mode) |->
      pulldown_100k == (power_mode == SDFL_PM_100K_E)) else $error("100k decode");
   hiz_decode_a: assert property ($stable(power_mode) |->
      out_hiz == (power_mode == SDFL_PM_HIZ_E)) else $error("hiz decode");
   reset_zero_a: assert property ($past(rst) |->
      dac_code == 16'h0000 && power_mode == SDFL_PM_NORMAL_E) else $error("reset value");
   tap_onehot_a: assert property (!$past(rst) |-> $onehot(tap_switch))
      else $error("tap not one-hot");
   tap_match_a: assert property (!$past(rst) && $stable(dac_code) |->
      tap_switch[dac_code[`SDFL_CODE_HI -: SW_W]]) else $error("tap mismatch");
   idle_stable_a: assert property (quiet_ff == 5'h14 |->
      $stable(dac_code) && $stable(power_mode)) else $error("update without frame");
   hiz_c: cover property (power_mode == SDFL_PM_HIZ_E);
   full_c: cover property ($fell(frame_ready));
   load_c: cover property ($changed(dac_code));
endmodule : sdfl_asserts

bind sdfl_top sdfl_asserts #(.SW_W(SW_W)) i_sdfl_asserts (.clk(clk), .rst(rst),
   .sclk(sclk), .update_hold(update_hold), .frame_ready(frame_ready),
   .dac_code(dac_code), .power_mode(power_mode), .amp_enable(amp_enable),
   .pulldown_1k(pulldown_1k), .pulldown_100k(pulldown_100k), .out_hiz(out_hiz),
   .tap_switch(tap_switch));

// ### test/sdfl_host_model.sv
// Purpose: Host serial master for the frame loader link.
// Assumes: sclk idles low and stands still outside frames.
// Notes:   Released data shows the inverse of the last bit.
module sdfl_host_model (
   output logic sclk,
   output logic sync_n,
   output logic din
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'b0;
      sync_n = 1'b1;
      din = 1'b1;
   end
   // ==========
   // Frame sender, 160 ns link period
   task automatic send(input logic [23:0] frame, input int nbits, input bit keep_low);
      if (!sync_n) begin
         sync_n = 1'b1;
         #40;
      end
      sync_n = 1'b0;
      #37.3;
      for (int i = 23; i > 23 - nbits; i--) begin
         din = frame[i];
         sclk = 1'b1;
         #80;
         sclk = 1'b0;
         #80;
      end
      din = ~din;
      if (!keep_low) sync_n = 1'b1;
      #40;
   endtask : send
endmodule : sdfl_host_model

// ### test/sdfl_tb_top.sv
// Purpose: Self-checking bench of the frame loader.
// Assumes: Host model drives the link; hold and reset come from here.
// Notes:   SW_W cut to 4 so the tap vector stays small.
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
   $display("Error at %0t: got %0h exp %0h", $time, (a), (e)); end end

module sdfl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sdfl_pkg::*;
   localparam int SW_W = 4;
   logic        clk, rst, sclk, sync_n, din, update_hold, frame_ready;
   logic        amp_enable, pulldown_1k, pulldown_100k, out_hiz;
   logic [15:0] dac_code, tap_switch;
   sdfl_pmode_t power_mode;
   int          err_count, checked, cycles;

   sdfl_top #(.SW_W(SW_W)) i_sdfl_top (.clk(clk), .rst(rst), .sclk(sclk),
      .sync_n(sync_n), .din(din), .update_hold(update_hold),
      .frame_ready(frame_ready), .dac_code(dac_code), .power_mode(power_mode),
      .amp_enable(amp_enable), .pulldown_1k(pulldown_1k),
      .pulldown_100k(pulldown_100k), .out_hiz(out_hiz), .tap_switch(tap_switch));
   sdfl_host_model i_sdfl_host_model (.sclk(sclk), .sync_n(sync_n), .din(din));

   always #5 clk = ~clk;
   // Whole run needs about 4800 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         err_count++;
         end_sim();
      end
   end
   // ==========
   // Tasks
   task automatic expect_out(input logic [15:0] code, input logic [1:0] mode);
      repeat (12) @(negedge clk);
      `CHK(dac_code, code)
      `CHK(power_mode, mode)
      `CHK({amp_enable, pulldown_1k, pulldown_100k, out_hiz}, 4'h8 >> mode)
      `CHK(tap_switch, 16'h0001 << code[15:12])
   endtask : expect_out

   task automatic t_reset;
      expect_out(16'h0000, 2'h0);
      `CHK(frame_ready, 1'b1)
      $display("t_reset done");
   endtask : t_reset

   task automatic t_modes;
      logic [15:0] codes [4];
      codes = '{16'hFFFF, 16'h0000, 16'h8001, 16'h7FFE};
      for (int m = 0; m < 4; m++) begin
         i_sdfl_host_model.send({6'h3F, m[1:0], codes[m]}, 24, m[0]);
         expect_out(codes[m], m[1:0]);
      end
      $display("t_modes done");
   endtask : t_modes

   task automatic t_abort;
      i_sdfl_host_model.send(24'h001234, 23, 1'b0);
      expect_out(16'h7FFE, 2'h3);
      i_sdfl_host_model.send(24'h001234, 24, 1'b0);
      expect_out(16'h1234, 2'h0);
      $display("t_abort done");
   endtask : t_abort

   task automatic t_hold;
      @(negedge clk);
      update_hold = 1'b1;
      for (int i = 0; i < 6; i++) i_sdfl_host_model.send(24'h00A000 + 24'(i), 24, 1'b0);
      repeat (12) @(negedge clk);
      `CHK(frame_ready, 1'b0)
      `CHK(dac_code, 16'h1234)
      update_hold = 1'b0;
      // Four frames fill the FIFO; the fifth and sixth are dropped
      expect_out(16'hA003, 2'h0);
      `CHK(frame_ready, 1'b1)
      $display("t_hold done");
   endtask : t_hold

   task automatic end_sim;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      update_hold = 1'b0;
      err_count = 0;
      checked = 0;
      cycles = 0;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_modes();
      t_abort();
      t_hold();
      end_sim();
   end
endmodule : sdfl_tb_top
